// File: hdl/beh_handler.sv
// Bus error handler for one descriptor-driven transmit context.
// Assumes the fetch engine, payload reader and link run on CLOCK_I and report
// host bus failures as one-cycle pulses tagged with the processing stage.
// Functional notes
// - Errors affect only this context; other contexts keep running untouched.
// - A context restart input recovers this context without a controller reset.
// - Response depends on failure stage, not kind of bus failure.
// - Descriptor fetch failure sets halted flag and loads fetch-failure code.
// - Fetch failure raises fatal error event, no context interrupt.
// - After fetch or status failure pointer stays inside the failing block.
// - Fetch failure writes no transfer outcome or remaining count.
// - Status write failure halts context, keeps intended status readable.
// - Status write failure raises fatal event, suppresses context interrupt.
// - With queued packets, failed status write waits a split timeout, drops responses.
// - After the wait and FIFO drain, set halted flag and fatal event.
// - Payload read failure keeps context running, records read or underrun code.
// - Failure before header entered FIFO aborts packet and moves on.
// - Failure after header stops feeding FIFO, truncating the packet.
// - Truncated packet: ack_data_error stores failure code, other acks stored as is.
// - No-ack truncated packets behave as if ack_data_error returned.
module beh_handler #(
   parameter int SPLIT_CYCLES = beh_pkg::SPLIT_TIMEOUT_CYC
) (
   // Clock and reset
   input  wire logic                      CLOCK_I,
   input  wire logic                      RST_B_I,
   // Context control
   input  wire logic                      RUN_I,
   input  wire logic                      RESTART_I,
   input  wire logic                      QUEUED_I,
   // Host bus failure report
   input  wire logic                      BUS_ERR_I,
   input  wire logic [1:0]                BUS_ERR_STAGE_I,
   input  wire logic                      UNDERRUN_I,
   // Descriptor tracking
   input  wire logic                      DESC_ADVANCE_I,
   input  wire logic [31:0]               DESC_ADDR_I,
   input  wire logic [15:0]               STATUS_WB_I,
   input  wire logic                      STATUS_WB_VALID_I,
   // Payload into output FIFO
   input  wire logic [beh_pkg::DATA_W-1:0] PAY_DATA_I,
   input  wire logic                      PAY_VALID_I,
   input  wire logic                      PAY_HEADER_I,
   input  wire logic                      PAY_LAST_I,
   output logic                           PAY_READY_O,
   // Link side
   output logic [beh_pkg::DATA_W-1:0]     LINK_DATA_O,
   output logic                           LINK_VALID_O,
   input  wire logic                      LINK_READY_I,
   input  wire logic                      ACK_VALID_I,
   input  wire logic [3:0]                ACK_CODE_I,
   input  wire logic                      NO_ACK_I,
   input  wire logic                      RESP_VALID_I,
   // Status outputs
   output logic                           HALTED_O,
   output logic [4:0]                     EVENT_CODE_O,
   output logic [15:0]                    KEPT_STATUS_O,
   output logic [31:0]                    DESC_PTR_O,
   output logic                           FATAL_EVENT_O,
   output logic                           CTX_INT_O,
   output logic                           OUTCOME_WE_O,
   output logic [4:0]                     OUTCOME_O,
   output logic                           ABORT_O,
   output logic                           RESP_DROP_O
);
   // ************************************************************
   // Declarations
   // ************************************************************
   beh_pkg::beh_state_e state_reg;
   logic        fetch_err;
   logic        pay_err;
   logic        stat_err;
   logic        header_in_reg;
   logic        truncating_reg;
   logic        trunc_pending_reg;
   logic [4:0]  fail_code_reg;
   logic        timer_start;
   logic        timer_busy;
   logic        timer_done;
   logic        fifo_empty;
   logic        fifo_in_ready;
   logic        fifo_out_valid;
   logic [beh_pkg::DATA_W-1:0] fifo_out_data;
   logic        fifo_push;

   // Stage alone picks the response
   assign fetch_err = BUS_ERR_I && (BUS_ERR_STAGE_I == beh_pkg::STAGE_FETCH);
   assign pay_err   = BUS_ERR_I && (BUS_ERR_STAGE_I == beh_pkg::STAGE_PAYLOAD);
   assign stat_err  = BUS_ERR_I && (BUS_ERR_STAGE_I == beh_pkg::STAGE_STATUS);

   function automatic logic [4:0] read_code(input logic underrun);
      read_code = underrun ? beh_pkg::EVT_UNDERRUN : beh_pkg::EVT_DATA_READ;
   endfunction : read_code

   // ************************************************************
   // Output FIFO
   // ************************************************************
   // Feeding stops once truncating, so the link sends a short packet
   assign fifo_push   = PAY_VALID_I && !truncating_reg && !pay_err &&
                        (state_reg == beh_pkg::ST_RUN);
   assign PAY_READY_O = fifo_in_ready && (state_reg == beh_pkg::ST_RUN);

   beh_fifo #(
      .WIDTH (beh_pkg::DATA_W),
      .DEPTH (beh_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (CLOCK_I),
      .rst_b_i     (RST_B_I),
      .in_data_i   (PAY_DATA_I),
      .in_valid_i  (fifo_push),
      .in_ready_o  (fifo_in_ready),
      .out_data_o  (fifo_out_data),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (LINK_READY_I && !LINK_VALID_O),
      .flush_i     (RESTART_I),
      .empty_o     (fifo_empty)
   );

   // Output register stage keeps link outputs straight from flops
   always_ff @(posedge CLOCK_I)
   begin
      if (!RST_B_I)
      begin
         LINK_DATA_O  <= '0;
         LINK_VALID_O <= 1'b0;
      end
      else if (LINK_VALID_O && LINK_READY_I)
      begin
         LINK_VALID_O <= 1'b0;
      end
      else if (!LINK_VALID_O && fifo_out_valid && LINK_READY_I)
      begin
         LINK_DATA_O  <= fifo_out_data;
         LINK_VALID_O <= 1'b1;
      end
   end

   // ************************************************************
   // Split timeout
   // ************************************************************
   assign timer_start = stat_err && QUEUED_I && (state_reg == beh_pkg::ST_RUN);

   beh_timer #(
      .COUNT (SPLIT_CYCLES)
   ) u_timer (
      .clk_i   (CLOCK_I),
      .rst_b_i (RST_B_I && !RESTART_I),
      .start_i (timer_start),
      .busy_o  (timer_busy),
      .done_o  (timer_done)
   );

   // ************************************************************
   // Context state
   // ************************************************************
   // Only this context's state reacts; no shared controller state is touched
   always_ff @(posedge CLOCK_I)
   begin
      if (!RST_B_I)
      begin
         state_reg <= beh_pkg::ST_IDLE;
      end
      else if (RESTART_I)
      begin
         state_reg <= beh_pkg::ST_IDLE;
      end
      else
      begin
         case (state_reg)
            beh_pkg::ST_IDLE:
            begin
               if (RUN_I)
               begin
                  state_reg <= beh_pkg::ST_RUN;
               end
            end
            beh_pkg::ST_RUN:
            begin
               if (fetch_err)
               begin
                  state_reg <= beh_pkg::ST_HALTED;
               end
               else if (timer_start)
               begin
                  state_reg <= beh_pkg::ST_SPLIT_WAIT;
               end
               else if (stat_err)
               begin
                  state_reg <= beh_pkg::ST_HALTED;
               end
            end
            beh_pkg::ST_SPLIT_WAIT:
            begin
               if (timer_done)
               begin
                  state_reg <= beh_pkg::ST_DRAIN;
               end
            end
            beh_pkg::ST_DRAIN:
            begin
               if (fifo_empty && !LINK_VALID_O)
               begin
                  state_reg <= beh_pkg::ST_HALTED;
               end
            end
            default:
            begin
               state_reg <= state_reg;
            end
         endcase
      end
   end

   always_ff @(posedge CLOCK_I)
   begin
      if (!RST_B_I)
      begin
         HALTED_O      <= 1'b0;
         EVENT_CODE_O  <= beh_pkg::EVT_NONE;
         KEPT_STATUS_O <= beh_pkg::STATUS_RESET;
         FATAL_EVENT_O <= 1'b0;
      end
      else if (RESTART_I)
      begin
         HALTED_O      <= 1'b0;
         EVENT_CODE_O  <= beh_pkg::EVT_NONE;
         FATAL_EVENT_O <= 1'b0;
      end
      else if (state_reg == beh_pkg::ST_RUN && fetch_err)
      begin
         HALTED_O      <= 1'b1;
         EVENT_CODE_O  <= beh_pkg::EVT_DESC_READ;
         FATAL_EVENT_O <= 1'b1;
      end
      else if (state_reg == beh_pkg::ST_RUN && stat_err)
      begin
         KEPT_STATUS_O <= STATUS_WB_I;
         if (!QUEUED_I)
         begin
            HALTED_O      <= 1'b1;
            FATAL_EVENT_O <= 1'b1;
         end
      end
      else if (state_reg == beh_pkg::ST_DRAIN && fifo_empty && !LINK_VALID_O)
      begin
         HALTED_O      <= 1'b1;
         FATAL_EVENT_O <= 1'b1;
      end
   end

   // Pointer freezes on the failing descriptor; it moves only while running
   always_ff @(posedge CLOCK_I)
   begin
      if (!RST_B_I)
      begin
         DESC_PTR_O <= beh_pkg::PTR_RESET;
      end
      else if (DESC_ADVANCE_I && state_reg == beh_pkg::ST_RUN && !BUS_ERR_I)
      begin
         DESC_PTR_O <= DESC_ADDR_I;
      end
   end

   // Context interrupt is only a completed, error-free write-back
   always_ff @(posedge CLOCK_I)
   begin
      if (!RST_B_I)
      begin
         CTX_INT_O <= 1'b0;
      end
      else
      begin
         CTX_INT_O <= STATUS_WB_VALID_I && !BUS_ERR_I &&
                      state_reg == beh_pkg::ST_RUN;
      end
   end

   // Responses during the split wait are dropped
   always_ff @(posedge CLOCK_I)
   begin
      if (!RST_B_I)
      begin
         RESP_DROP_O <= 1'b0;
      end
      else
      begin
         RESP_DROP_O <= RESP_VALID_I && (state_reg == beh_pkg::ST_SPLIT_WAIT ||
                                         timer_busy);
      end
   end

   // ************************************************************
   // Payload read failure
   // ************************************************************
   always_ff @(posedge CLOCK_I)
   begin
      if (!RST_B_I || RESTART_I)
      begin
         header_in_reg     <= 1'b0;
         truncating_reg    <= 1'b0;
         trunc_pending_reg <= 1'b0;
         fail_code_reg     <= beh_pkg::EVT_NONE;
      end
      else if (state_reg == beh_pkg::ST_RUN)
      begin
         if (fifo_push && PAY_HEADER_I)
         begin
            header_in_reg <= 1'b1;
         end
         if (pay_err && (header_in_reg || (fifo_push && PAY_HEADER_I)))
         begin
            truncating_reg    <= 1'b1;
            trunc_pending_reg <= 1'b1;
            fail_code_reg     <= read_code(UNDERRUN_I);
         end
         if (PAY_VALID_I && PAY_READY_O && PAY_LAST_I)
         begin
            header_in_reg  <= 1'b0;
            truncating_reg <= 1'b0;
         end
         if (trunc_pending_reg && (ACK_VALID_I || NO_ACK_I))
         begin
            trunc_pending_reg <= 1'b0;
         end
      end
   end

   // Outcome written to the last output descriptor; never on fetch failure
   always_ff @(posedge CLOCK_I)
   begin
      if (!RST_B_I)
      begin
         OUTCOME_WE_O <= 1'b0;
         OUTCOME_O    <= beh_pkg::EVT_NONE;
         ABORT_O      <= 1'b0;
      end
      else
      begin
         OUTCOME_WE_O <= 1'b0;
         ABORT_O      <= 1'b0;
         if (state_reg == beh_pkg::ST_RUN && !fetch_err)
         begin
            if (pay_err && !header_in_reg && !(fifo_push && PAY_HEADER_I))
            begin
               ABORT_O      <= 1'b1;
               OUTCOME_WE_O <= 1'b1;
               OUTCOME_O    <= read_code(UNDERRUN_I);
            end
            else if (trunc_pending_reg && NO_ACK_I)
            begin
               OUTCOME_WE_O <= 1'b1;
               OUTCOME_O    <= fail_code_reg;
            end
            else if (trunc_pending_reg && ACK_VALID_I)
            begin
               OUTCOME_WE_O <= 1'b1;
               OUTCOME_O    <= (ACK_CODE_I == beh_pkg::ACK_DATA_ERROR) ?
                               fail_code_reg : {1'b0, ACK_CODE_I};
            end
         end
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   chk_fetch_halts: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
      (state_reg == beh_pkg::ST_RUN && fetch_err && !RESTART_I) |=>
      HALTED_O && EVENT_CODE_O == beh_pkg::EVT_DESC_READ)
      else $error("fetch failure did not halt");
   chk_fetch_fatal: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
      (state_reg == beh_pkg::ST_RUN && fetch_err && !RESTART_I) |=>
      FATAL_EVENT_O && !CTX_INT_O)
      else $error("fetch failure interrupt wrong");
   chk_fetch_no_outcome: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
      (state_reg == beh_pkg::ST_RUN && fetch_err) |=> !OUTCOME_WE_O)
      else $error("outcome written on fetch failure");
   chk_ptr_frozen: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
      HALTED_O |=> $stable(DESC_PTR_O))
      else $error("pointer moved while halted");
   chk_status_kept: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
      (state_reg == beh_pkg::ST_RUN && stat_err && !RESTART_I) |=>
      KEPT_STATUS_O == $past(STATUS_WB_I))
      else $error("intended status not kept");
   chk_status_fatal: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
      (state_reg == beh_pkg::ST_RUN && stat_err && !QUEUED_I && !RESTART_I) |=>
      FATAL_EVENT_O && HALTED_O && !CTX_INT_O)
      else $error("status failure interrupt wrong");
   chk_wait_drops: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
      (state_reg == beh_pkg::ST_SPLIT_WAIT && RESP_VALID_I) |=> RESP_DROP_O)
      else $error("response kept during split wait");
   chk_drain_halt: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
      (state_reg == beh_pkg::ST_DRAIN && fifo_empty && !LINK_VALID_O && !RESTART_I)
      |=> HALTED_O && FATAL_EVENT_O)
      else $error("drain did not halt");
   chk_truncate_stops: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
      truncating_reg |-> !fifo_push)
      else $error("fed fifo while truncating");
   chk_no_ack_error: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
      (state_reg == beh_pkg::ST_RUN && trunc_pending_reg && NO_ACK_I && !pay_err
       && !RESTART_I) |=> OUTCOME_WE_O && OUTCOME_O == $past(fail_code_reg))
      else $error("no-ack truncation code wrong");

   cov_fetch_fail: cover property (@(posedge CLOCK_I) fetch_err && state_reg == beh_pkg::ST_RUN);
   cov_split_wait: cover property (@(posedge CLOCK_I) state_reg == beh_pkg::ST_SPLIT_WAIT);
   cov_truncate: cover property (@(posedge CLOCK_I) trunc_pending_reg && ACK_VALID_I);
   cov_abort: cover property (@(posedge CLOCK_I) ABORT_O);
endmodule : beh_handler

// File: hdl/beh_pkg.sv
// Constants and types for the context bus error handler.
// Assumes a single 125 MHz controller clock and synchronous active-low reset.
package beh_pkg;
   // ************************************************************
   // Event codes within the context event field
   // ************************************************************
   localparam logic [4:0] EVT_NONE       = 5'h00;
   localparam logic [4:0] EVT_DESC_READ  = 5'h10; // Arbitrary distinct encodings
   localparam logic [4:0] EVT_DATA_READ  = 5'h11;
   localparam logic [4:0] EVT_UNDERRUN   = 5'h12;
   localparam logic [4:0] EVT_ACK_MARK   = 5'h00;

   // ************************************************************
   // Acknowledge codes and flags
   // ************************************************************
   localparam logic [3:0] ACK_DATA_ERROR = 4'hD;
   localparam logic [3:0] ACK_NONE       = 4'h0;

   // ************************************************************
   // Stage encodings and reset values
   // ************************************************************
   localparam logic [1:0] STAGE_FETCH    = 2'h0;
   localparam logic [1:0] STAGE_PAYLOAD  = 2'h1;
   localparam logic [1:0] STAGE_STATUS   = 2'h2;
   localparam logic [15:0] STATUS_RESET  = 16'h0000;
   localparam logic [31:0] PTR_RESET     = 32'h0000_0000;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLOCK_MHZ        = 125;
   localparam int SPLIT_TIMEOUT_US = 100;
   localparam int SPLIT_TIMEOUT_CYC = SPLIT_TIMEOUT_US * CLOCK_MHZ;

   // ************************************************************
   // Data path
   // ************************************************************
   localparam int DATA_W     = 32;
   localparam int FIFO_DEPTH = 4;

   typedef enum {
      ST_IDLE,
      ST_RUN,
      ST_SPLIT_WAIT,
      ST_DRAIN,
      ST_HALTED
   } beh_state_e;
endpackage : beh_pkg

// File: hdl/beh_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and synchronous active-low reset.
module beh_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_b_i,
   // Fill side
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   // Drain side
   output logic [WIDTH-1:0]      out_data_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   // Flush control and status
   input  wire logic             flush_i,
   output logic                  empty_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic             push;
   logic             pop;

   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : ptr_inc

   assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
   assign out_valid_o = (count_reg != '0);
   assign empty_o     = (count_reg == '0);
   assign out_data_o  = mem[rd_ptr_reg];
   assign push        = in_valid_i && in_ready_o && !flush_i;
   assign pop         = out_valid_o && out_ready_i && !flush_i;

   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         mem[wr_ptr_reg] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i || flush_i)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_reg <= ptr_inc(wr_ptr_reg);
         end
         if (pop)
         begin
            rd_ptr_reg <= ptr_inc(rd_ptr_reg);
         end
         if (push && !pop)
         begin
            count_reg <= count_reg + 1'b1;
         end
         else if (pop && !push)
         begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end

   chk_fifo_no_overflow: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      count_reg <= (AW+1)'(DEPTH))
      else $error("fifo count above depth");
endmodule : beh_fifo

// File: hdl/beh_timer.sv
// Split-timeout wait counter.
// Assumes one clock; start is a one-cycle pulse from the same domain.
module beh_timer #(
   parameter int COUNT = 12500
) (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   // Control
   input  wire logic start_i,
   output logic      busy_o,
   output logic      done_o
);
   logic [31:0] cnt_reg;

   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         cnt_reg <= 32'h0000_0000;
         busy_o  <= 1'b0;
         done_o  <= 1'b0;
      end
      else
      begin
         done_o <= 1'b0;
         if (start_i)
         begin
            cnt_reg <= 32'(COUNT - 1);
            busy_o  <= 1'b1;
         end
         else if (busy_o)
         begin
            if (cnt_reg == 32'h0000_0000)
            begin
               busy_o <= 1'b0;
               done_o <= 1'b1;
            end
            else
            begin
               cnt_reg <= cnt_reg - 1'b1;
            end
         end
      end
   end
endmodule : beh_timer

// File: sim/beh_link_model.sv
// Link partner: takes words from the handler's link side.
// Assumes one clock; stall_i freezes acceptance to back up the FIFO.
module beh_link_model (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   // Link handshake
   input  wire logic valid_i,
   input  wire logic stall_i,
   output logic      ready_o,
   output int        count_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic toggle_reg;
   // Half rate acceptance, so the link is slow even when not stalled
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         toggle_reg <= 1'b0;
         count_o    <= 0;
      end
      else
      begin
         toggle_reg <= !toggle_reg;
         if (valid_i && ready_o)
            count_o <= count_o + 1;
      end
   end
   assign ready_o = !stall_i && toggle_reg;
endmodule : beh_link_model

// File: sim/testbench.sv
// Self-checking bench for the context bus error handler.
// Assumes beh_pkg and the hdl modules are compiled first.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst_b = 1'b0, run = 1'b0, restart = 1'b0, queued = 1'b0;
   logic bus_err = 1'b0, underrun = 1'b0, adv = 1'b0, wb_v = 1'b0, pvalid = 1'b0;
   logic phdr = 1'b0, plast = 1'b0, ackv = 1'b0, noack = 1'b0, respv = 1'b0, stall = 1'b0;
   logic [1:0] stage = 2'h0;
   logic [3:0] ackc = 4'h0;
   logic [15:0] wb = 16'h0000;
   logic [31:0] addr = 32'h0000_0000, pdata = 32'h0000_0000, ldata, ptr;
   logic pready, lvalid, lready, halted, fatal, cint, owe, abort, rdrop;
   logic [4:0] evt, outc;
   logic [15:0] kept;
   int errors = 0, checked = 0, words;
   beh_handler #(.SPLIT_CYCLES(20)) i_dut (.CLOCK_I(clk), .RST_B_I(rst_b), .RUN_I(run),
      .RESTART_I(restart), .QUEUED_I(queued), .BUS_ERR_I(bus_err), .BUS_ERR_STAGE_I(stage),
      .UNDERRUN_I(underrun), .DESC_ADVANCE_I(adv), .DESC_ADDR_I(addr), .STATUS_WB_I(wb),
      .STATUS_WB_VALID_I(wb_v), .PAY_DATA_I(pdata), .PAY_VALID_I(pvalid), .PAY_HEADER_I(phdr),
      .PAY_LAST_I(plast), .PAY_READY_O(pready), .LINK_DATA_O(ldata), .LINK_VALID_O(lvalid),
      .LINK_READY_I(lready), .ACK_VALID_I(ackv), .ACK_CODE_I(ackc), .NO_ACK_I(noack),
      .RESP_VALID_I(respv), .HALTED_O(halted), .EVENT_CODE_O(evt), .KEPT_STATUS_O(kept),
      .DESC_PTR_O(ptr), .FATAL_EVENT_O(fatal), .CTX_INT_O(cint), .OUTCOME_WE_O(owe),
      .OUTCOME_O(outc), .ABORT_O(abort), .RESP_DROP_O(rdrop));
   beh_link_model i_link (.clk_i(clk), .rst_b_i(rst_b), .valid_i(lvalid), .stall_i(stall),
      .ready_o(lready), .count_o(words));
   always #4 clk = !clk;
   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic tick(int n = 1);
      repeat (n) @(negedge clk);
   endtask : tick
   task automatic check(string nm, logic [31:0] e, logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         errors++;
         $display("ERROR %s expected %0h seen %0h", nm, e, g);
      end
   endtask : check
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : stop_test
   task automatic start();
      run = 1'b0;
      restart = 1'b1;
      tick();
      restart = 1'b0;
      run = 1'b1;
      tick(2);
   endtask : start
   task automatic err(logic [1:0] s, logic u);
      bus_err = 1'b1;
      stage = s;
      underrun = u;
      tick();
      bus_err = 1'b0;
   endtask : err
   task automatic wait_for(ref logic sig, input int lim);
      int n;
      n = 0;
      while (sig !== 1'b1 && n < lim)
      begin
         tick();
         n++;
      end
      if (sig !== 1'b1)
      begin
         errors++;
         $display("ERROR wait expected 1 seen %b", sig);
         stop_test();
      end
   endtask : wait_for
   task automatic push(logic [31:0] d, logic h, logic l);
      pdata = d;
      phdr = h;
      plast = l;
      pvalid = 1'b1;
      tick();
      pvalid = 1'b0;
   endtask : push
   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_fetch();
      start();
      adv = 1'b1;
      addr = 32'h0000_1040;
      tick();
      adv = 1'b0;
      err(2'h0, 1'b0);
      check("halted", 1, halted);
      check("event", beh_pkg::EVT_DESC_READ, evt);
      check("fatal", 1, fatal);
      check("ctx int", 0, cint);
      check("outcome we", 0, owe);
      check("pointer", 32'h0000_1040, ptr);
      start();
      check("halted after restart", 0, halted);
      check("fatal after restart", 0, fatal);
      $display("fetch failure done");
   endtask : t_fetch
   task automatic t_status();
      start();
      wb_v = 1'b1;
      tick();
      check("ctx int ok", 1, cint);
      wb = 16'h5A3C;
      err(2'h2, 1'b0);
      wb_v = 1'b0;
      check("halted", 1, halted);
      check("kept status", 16'h5A3C, kept);
      check("fatal", 1, fatal);
      check("ctx int", 0, cint);
      $display("status failure done");
   endtask : t_status
   task automatic t_pre_header();
      start();
      for (int u = 0; u < 2; u++)
      begin
         err(2'h1, u[0]);
         check("abort", 1, abort);
         check("outcome", u ? beh_pkg::EVT_UNDERRUN : beh_pkg::EVT_DATA_READ, outc);
         check("halted", 0, halted);
         tick(2);
      end
      $display("pre header failure done");
   endtask : t_pre_header
   task automatic t_trunc();
      int w0;
      logic [4:0] exp [3] = '{beh_pkg::EVT_UNDERRUN, 5'h02, beh_pkg::EVT_DATA_READ};
      start();
      for (int k = 0; k < 3; k++)
      begin
         wait_for(pready, 40);
         w0 = words;
         push(32'hC0DE_0010, 1'b1, 1'b0);
         err(2'h1, k == 0);
         push(32'h1111_2222, 1'b0, 1'b1);
         tick(12);
         check("words sent", w0 + 1, words);
         check("link data", 32'hC0DE_0010, ldata);
         ackc = (k == 0) ? beh_pkg::ACK_DATA_ERROR : 4'h2;
         ackv = (k < 2);
         noack = (k == 2);
         tick();
         ackv = 1'b0;
         noack = 1'b0;
         wait_for(owe, 40);
         check("outcome", exp[k], outc);
         check("halted", 0, halted);
      end
      $display("truncation done");
   endtask : t_trunc
   task automatic t_fill();
      int i;
      start();
      stall = 1'b1;
      tick(4);
      i = 0;
      pvalid = 1'b1;
      while (i < 8)
      begin
         pdata = i;
         #1;
         if (pready !== 1'b1)
            break;
         tick();
         i++;
      end
      pvalid = 1'b0;
      check("fifo refused", 1, i >= 4 && i < 8);
      stall = 1'b0;
      tick(30);
      check("all words drained", i, words);
      check("last word", i - 1, ldata);
      $display("fill and drain done");
   endtask : t_fill
   task automatic t_queued();
      start();
      queued = 1'b1;
      wb = 16'h00AB;
      err(2'h2, 1'b0);
      check("halted early", 0, halted);
      respv = 1'b1;
      tick();
      respv = 1'b0;
      check("resp dropped", 1, rdrop);
      tick(17);
      check("halted in wait", 0, halted);
      wait_for(halted, 40);
      check("fatal", 1, fatal);
      check("kept status", 16'h00AB, kept);
      queued = 1'b0;
      $display("queued status failure done");
   endtask : t_queued
   initial
   begin
      tick(16);
      rst_b = 1'b1;
      t_fill();
      t_fetch();
      t_status();
      t_pre_header();
      t_trunc();
      t_queued();
      stop_test();
   end
endmodule : testbench
